// ### rtl/wsi_store_exec.sv
// Purpose: executes accumulator stores, option load, no-operation and software reset
// Assumes: instruction clock clk_i, one decoded instruction per cycle
// Notes: status flags are owned elsewhere; this block never drives them
// Contract
// - direct store copies the accumulator to file register 0..127, flags untouched.
// - indirect store writes the accumulator at the address held by pointer 0 or 1.
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; pre uses the new address.
// - relative form stores at pointer plus signed offset -32..31, pointer unchanged.
// - pointers are 16-bit and wrap at both ends.
// - indirect store and pointer update change no status flag.
// - option load copies the accumulator into the option register, flags untouched.
// - software reset resets the device and clears reset_instr_flag_n.
`timescale 1ns/1ps
module wsi_store_exec (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic por_i,
    input wire wsi_pkg::wsi_instr_type instr_i,
    input wire logic [wsi_pkg::ACC_W-1:0] acc_i,
    output wsi_pkg::wsi_write_type wr_o,
    output logic [wsi_pkg::PTR_W-1:0] indirect_pointer0_o,
    output logic [wsi_pkg::PTR_W-1:0] indirect_pointer1_o,
    output logic [wsi_pkg::ACC_W-1:0] option_o,
    output logic [wsi_pkg::PC_W-1:0] pc_o,
    output logic soft_reset_o,
    output logic reset_instr_flag_n_o
);

    // ****************************************
    // address arithmetic
    // ****************************************
    logic [wsi_pkg::PTR_W-1:0] ptr_r [2];
    logic [wsi_pkg::PTR_W-1:0] ptr_cur;
    logic [wsi_pkg::PTR_W-1:0] ptr_upd;
    logic [wsi_pkg::PTR_W-1:0] ptr_rel;
    logic [wsi_pkg::PTR_W-1:0] eff_addr;
    logic is_inc;
    logic is_pre;
    logic exec;
    logic do_reset;
    logic dec_direct;
    logic dec_indirect;
    logic dec_relative;
    logic dec_option;
    logic [2:0] por_sync_r;
    logic por_seen;

    assign exec = instr_i.valid;
    assign ptr_cur = ptr_r[instr_i.ptr_sel];
    assign is_inc = (instr_i.pointer_update_mode == wsi_pkg::WSI_MODE_PRE_INC)
        || (instr_i.pointer_update_mode == wsi_pkg::WSI_MODE_POST_INC);
    assign is_pre = (instr_i.pointer_update_mode == wsi_pkg::WSI_MODE_PRE_INC)
        || (instr_i.pointer_update_mode == wsi_pkg::WSI_MODE_PRE_DEC);

    // ****************************************
    // instruction decode
    // ****************************************
    // one strobe per kind; unused codes fall to no-operation and only advance the program counter
    always_comb
    begin
        dec_direct = 1'b0;
        dec_indirect = 1'b0;
        dec_relative = 1'b0;
        dec_option = 1'b0;
        do_reset = 1'b0;
        if (exec)
        begin
            case (instr_i.op)
                wsi_pkg::WSI_OP_STORE_ACC_DIRECT:
                begin
                    dec_direct = 1'b1;
                end
                wsi_pkg::WSI_OP_STORE_ACC_INDIRECT:
                begin
                    dec_indirect = 1'b1;
                end
                wsi_pkg::WSI_OP_STORE_ACC_RELATIVE:
                begin
                    dec_relative = 1'b1;
                end
                wsi_pkg::WSI_OP_LOAD_OPTION:
                begin
                    dec_option = 1'b1;
                end
                wsi_pkg::WSI_OP_SOFT_RESET:
                begin
                    do_reset = 1'b1;
                end
                default:
                begin
                    dec_direct = 1'b0;
                end
            endcase
        end
    end

    // modulo 2^16 sum gives the wrap for free
    always_comb
    begin
        ptr_upd = is_inc ? ptr_cur + wsi_pkg::PTR_ONE : ptr_cur - wsi_pkg::PTR_ONE;
        ptr_rel = ptr_cur + {{(wsi_pkg::PTR_W-wsi_pkg::OFS_W){instr_i.offset[wsi_pkg::OFS_W-1]}},
            instr_i.offset};
        eff_addr = is_pre ? ptr_upd : ptr_cur;
    end

    // ****************************************
    // pointers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || do_reset)
        begin
            ptr_r[0] <= wsi_pkg::PTR_RST;
            ptr_r[1] <= wsi_pkg::PTR_RST;
        end
        else if (dec_indirect)
        begin
            ptr_r[instr_i.ptr_sel] <= ptr_upd;
        end
    end

    assign indirect_pointer0_o = ptr_r[0];
    assign indirect_pointer1_o = ptr_r[1];

    // ****************************************
    // memory write port
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || do_reset)
        begin
            wr_o <= '0;
        end
        else
        begin
            wr_o.valid <= 1'b0;
            wr_o.indirect <= 1'b0;
            wr_o.data <= acc_i;
            wr_o.addr <= wsi_pkg::PTR_RST;
            if (dec_direct)
            begin
                wr_o.valid <= 1'b1;
                wr_o.addr <= {{(wsi_pkg::PTR_W-wsi_pkg::FADDR_W){1'b0}}, instr_i.file_addr};
            end
            else if (dec_indirect)
            begin
                wr_o.valid <= 1'b1;
                wr_o.indirect <= 1'b1;
                wr_o.addr <= eff_addr;
            end
            else if (dec_relative)
            begin
                wr_o.valid <= 1'b1;
                wr_o.indirect <= 1'b1;
                wr_o.addr <= ptr_rel;
            end
        end
    end

    // ****************************************
    // option register
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || do_reset)
        begin
            option_o <= wsi_pkg::OPT_RST;
        end
        else if (dec_option)
        begin
            option_o <= acc_i;
        end
    end

    // ****************************************
    // program counter
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || do_reset)
        begin
            pc_o <= wsi_pkg::PC_RST;
        end
        else if (exec)
        begin
            pc_o <= pc_o + wsi_pkg::PC_STEP;
        end
    end

    // ****************************************
    // power-on indication synchroniser
    // ****************************************
    // comes from the supply monitor, not this clock; no reset so device reset cannot mask it
    always_ff @(posedge clk_i)
    begin
        por_sync_r <= {por_sync_r[1:0], por_i};
    end

    // counts only once the second and third stages are both high
    assign por_seen = por_sync_r[1] && por_sync_r[2];

    // ****************************************
    // software reset and cause flag
    // ****************************************
    // flag survives the reset it reports; only power-on sets it again
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            soft_reset_o <= 1'b0;
        end
        else
        begin
            soft_reset_o <= do_reset;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (do_reset)
        begin
            reset_instr_flag_n_o <= 1'b0;
        end
        else if (por_seen)
        begin
            reset_instr_flag_n_o <= 1'b1;
        end
    end

endmodule

// ### rtl/wsi_pkg.sv
// Purpose: shared constants and types for the accumulator store executor
// Assumes: one instruction presented per clock, decoded upstream into a struct
// Notes: pointer width and offset range fixed by the instruction set
package wsi_pkg;

    // ****************************************
    // widths and constants
    // ****************************************
    localparam int ACC_W = 8;
    localparam int FADDR_W = 7;
    localparam int PTR_W = 16;
    localparam int OFS_W = 6;
    localparam int PC_W = 15;
    localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [ACC_W-1:0] OPT_RST = 8'hff;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        WSI_OP_NO_OPERATION,
        WSI_OP_STORE_ACC_DIRECT,
        WSI_OP_STORE_ACC_INDIRECT,
        WSI_OP_STORE_ACC_RELATIVE,
        WSI_OP_LOAD_OPTION,
        WSI_OP_SOFT_RESET
    } wsi_op_type;

    typedef enum logic [1:0] {
        WSI_MODE_PRE_INC = 2'h0,
        WSI_MODE_PRE_DEC = 2'h1,
        WSI_MODE_POST_INC = 2'h2,
        WSI_MODE_POST_DEC = 2'h3
    } wsi_mode_type;

    typedef struct packed {
        logic valid;
        wsi_op_type op;
        logic [FADDR_W-1:0] file_addr;
        logic ptr_sel;
        wsi_mode_type pointer_update_mode;
        logic signed [OFS_W-1:0] offset;
    } wsi_instr_type;

    typedef struct packed {
        logic valid;
        logic indirect;
        logic [PTR_W-1:0] addr;
        logic [ACC_W-1:0] data;
    } wsi_write_type;

endpackage

// ### tb/wsi_store_exec_props.sv
// Purpose: port checks for the store executor
// Assumes: sync active-low reset, one instruction per edge
// Notes: status flags are not ports, so status flag rules are left to the design
`timescale 1ns/1ps
module wsi_store_exec_props (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire wsi_pkg::wsi_instr_type instr_i,
    input wire logic [7:0] acc_i,
    input wire wsi_pkg::wsi_write_type wr_o,
    input wire logic [15:0] indirect_pointer0_o,
    input wire logic [15:0] indirect_pointer1_o,
    input wire logic [7:0] option_o,
    input wire logic [14:0] pc_o,
    input wire logic soft_reset_o,
    input wire logic reset_instr_flag_n_o
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic v = instr_i.valid;
    wire logic dir = v && instr_i.op == wsi_pkg::WSI_OP_STORE_ACC_DIRECT;
    wire logic ind = v && instr_i.op == wsi_pkg::WSI_OP_STORE_ACC_INDIRECT;
    wire logic rel = v && instr_i.op == wsi_pkg::WSI_OP_STORE_ACC_RELATIVE;
    wire logic srst = v && instr_i.op == wsi_pkg::WSI_OP_SOFT_RESET;
    wire logic [15:0] p = instr_i.ptr_sel ? indirect_pointer1_o : indirect_pointer0_o;
    wire logic [15:0] np = p + (instr_i.pointer_update_mode[0] ? 16'hffff : 16'h0001);
    wire logic [15:0] ea = instr_i.pointer_update_mode[1] ? p : np;
    wire logic [15:0] ra = p + {{10{instr_i.offset[5]}}, instr_i.offset};
    a_direct_store: assert property (dir |=>
        {wr_o.valid, wr_o.indirect, wr_o.addr, wr_o.data} ==
        {2'h2, 9'h0, $past(instr_i.file_addr), $past(acc_i)}) else $error("direct store");
    a_indirect_store: assert property (
        ind |=> wr_o == {2'h3, $past(ea), $past(acc_i)}) else $error("indirect store");
    a_relative_store: assert property (rel |=> {wr_o.valid, wr_o.indirect} == 2'h3
        && wr_o.addr == $past(ra) && wr_o.data == $past(acc_i)
        && $stable(indirect_pointer0_o) && $stable(indirect_pointer1_o)) else $error("rel");
    a_ptr0_update: assert property (ind && !instr_i.ptr_sel |=>
        indirect_pointer0_o == $past(np) && $stable(indirect_pointer1_o)) else $error("ptr0");
    a_ptr1_update: assert property (ind && instr_i.ptr_sel |=>
        indirect_pointer1_o == $past(np) && $stable(indirect_pointer0_o)) else $error("ptr1");
    a_option_load: assert property (v && instr_i.op == wsi_pkg::WSI_OP_LOAD_OPTION |=>
        option_o == $past(acc_i) && !wr_o.valid) else $error("option load");
    a_soft_reset: assert property (srst |=> soft_reset_o && !reset_instr_flag_n_o
        && pc_o == 15'h0 && option_o == 8'hff ##1 soft_reset_o == $past(srst))
        else $error("soft reset");
    a_pc_advance: assert property (
        v && !srst |=> pc_o == $past(pc_o) + 15'h1) else $error("pc advance");
    a_idle_quiet: assert property (!v || instr_i.op == wsi_pkg::WSI_OP_NO_OPERATION |=>
        !wr_o.valid && $stable(option_o) && $stable(indirect_pointer0_o)
        && $stable(indirect_pointer1_o)) else $error("idle changed state");
    a_pc_hold: assert property (!v |=> $stable(pc_o)) else $error("pc moved while idle");
    cover property (ind && instr_i.pointer_update_mode == wsi_pkg::WSI_MODE_POST_DEC);
    cover property (rel && instr_i.offset == 6'h20);
    cover property (srst);
endmodule

// ### tb/wsi_store_exec_tb.sv
// Purpose: bench for the store executor
// Assumes: 10 MHz clock, sync active-low reset
// Notes: pointers start at zero so the wrap cases come first
`timescale 1ns/1ps
module wsi_store_exec_tb;
    // ****
    // stimulus table
    // ****
    typedef struct packed {
        wsi_pkg::wsi_op_type op;
        logic s;
        logic [1:0] m;
        logic [6:0] f;
        logic w;
        logic [15:0] ea;
        logic [15:0] pt;
    } wsi_row_type;
    localparam wsi_pkg::wsi_op_type DIR = wsi_pkg::WSI_OP_STORE_ACC_DIRECT;
    localparam wsi_pkg::wsi_op_type IND = wsi_pkg::WSI_OP_STORE_ACC_INDIRECT;
    localparam wsi_pkg::wsi_op_type REL = wsi_pkg::WSI_OP_STORE_ACC_RELATIVE;
    wsi_row_type rows [9] = '{'{DIR, 0, 0, 7'h7f, 1, 16'h007f, 16'h0},
        '{IND, 0, 1, 0, 1, 16'hffff, 16'hffff}, '{IND, 0, 0, 0, 1, 16'h0, 16'h0},
        '{IND, 1, 3, 0, 1, 16'h0, 16'hffff}, '{IND, 1, 2, 0, 1, 16'hffff, 16'h0},
        '{REL, 1, 0, 7'h20, 1, 16'hffe0, 16'h0}, '{REL, 0, 0, 7'h1f, 1, 16'h001f, 16'h0},
        '{wsi_pkg::WSI_OP_LOAD_OPTION, 0, 0, 0, 0, 0, 0},
        '{wsi_pkg::WSI_OP_NO_OPERATION, 0, 0, 0, 0, 0, 0}};
    logic clk_i = 0, reset_n_i = 0, por_i = 1, soft_reset_o, reset_instr_flag_n_o;
    wsi_pkg::wsi_instr_type instr_i = '0;
    logic [7:0] acc_i = 0, option_o;
    wsi_pkg::wsi_write_type wr_o;
    logic [15:0] indirect_pointer0_o, indirect_pointer1_o;
    logic [14:0] pc_o;
    int num_errors = 0, n_compared = 0;
    wsi_store_exec dut_u (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .por_i(por_i),
        .instr_i(instr_i),
        .acc_i(acc_i),
        .wr_o(wr_o),
        .indirect_pointer0_o(indirect_pointer0_o),
        .indirect_pointer1_o(indirect_pointer1_o),
        .option_o(option_o),
        .pc_o(pc_o),
        .soft_reset_o(soft_reset_o),
        .reset_instr_flag_n_o(reset_instr_flag_n_o)
    );
    always #50 clk_i = ~clk_i;
    task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task results();
    begin
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // watchdog well past the few dozen cycles needed
    initial
    begin
        #20000;
        num_errors++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1;
        por_i = 0;
        chk({option_o, pc_o, reset_instr_flag_n_o}, {8'hff, 15'h0, 1'b1});
        chk({indirect_pointer0_o, indirect_pointer1_o}, 32'h0);
        chk(wr_o.valid, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            instr_i = '{1'b1, rows[i].op, rows[i].f, rows[i].s,
                wsi_pkg::wsi_mode_type'(rows[i].m), rows[i].f[5:0]};
            acc_i = 8'h40 + 8'(i);
            @(posedge clk_i) #1;
            chk(wr_o.valid, rows[i].w);
            if (rows[i].w)
                chk({wr_o.indirect, wr_o.addr, wr_o.data}, {rows[i].op != DIR, rows[i].ea, acc_i});
            chk(rows[i].s ? indirect_pointer1_o : indirect_pointer0_o, rows[i].pt);
            chk(pc_o, i + 1);
        end
        chk(option_o, 8'h47);
        instr_i.op = wsi_pkg::WSI_OP_SOFT_RESET;
        @(posedge clk_i) #1;
        chk({soft_reset_o, reset_instr_flag_n_o, pc_o, option_o}, {2'h2, 15'h0, 8'hff});
        instr_i.valid = 1'b0;
        @(posedge clk_i) #1;
        chk({soft_reset_o, pc_o, wr_o.valid}, 17'h0);
        // mid-run reset clears the pointer but leaves the cause flag alone
        instr_i = '{1'b1, IND, 7'h0, 1'b0, wsi_pkg::WSI_MODE_POST_INC, 6'h0};
        @(posedge clk_i) #1;
        chk(indirect_pointer0_o, 16'h0001);
        reset_n_i = 0;
        instr_i.valid = 1'b0;
        @(posedge clk_i) #1;
        chk({indirect_pointer0_o, pc_o, reset_instr_flag_n_o}, 32'h0);
        // first instruction right at the first edge after release
        reset_n_i = 1;
        instr_i = '{1'b1, IND, 7'h0, 1'b1, wsi_pkg::WSI_MODE_PRE_DEC, 6'h0};
        acc_i = 8'h5a;
        @(posedge clk_i) #1;
        chk({wr_o.valid, wr_o.indirect, wr_o.addr, wr_o.data}, {2'h3, 16'hffff, 8'h5a});
        chk({indirect_pointer1_o, pc_o}, {16'hffff, 15'h1});
        // power-on indication needs the synchroniser stages before the flag returns
        instr_i.valid = 1'b0;
        por_i = 1;
        repeat (4) @(posedge clk_i);
        #1;
        chk(reset_instr_flag_n_o, 1'b1);
        por_i = 0;
        results();
    end
endmodule
bind wsi_store_exec wsi_store_exec_props u_props (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .instr_i(instr_i),
    .acc_i(acc_i),
    .wr_o(wr_o),
    .indirect_pointer0_o(indirect_pointer0_o),
    .indirect_pointer1_o(indirect_pointer1_o),
    .option_o(option_o),
    .pc_o(pc_o),
    .soft_reset_o(soft_reset_o),
    .reset_instr_flag_n_o(reset_instr_flag_n_o)
);
